// File: inc/csd_pkg.sv
// Shared constants and types for the chip-select decode unit.
package csd_pkg;
    localparam int          NUM_SEL        = 12;
    localparam int          AW             = 6;
    localparam int          DW             = 16;
    // Register offsets (word index on the plain register port).
    localparam logic [5:0]  REG_PA_A       = 6'h00;
    localparam logic [5:0]  REG_PA_B       = 6'h01;
    localparam logic [5:0]  REG_LATCH      = 6'h02;
    localparam logic [5:0]  REG_STATUS     = 6'h03;
    localparam logic [5:0]  REG_SEL_BASE   = 6'h20;
    localparam int          PA_A_FIELDS    = 7;
    // Base register layout.
    localparam int          BASE_ADDR_LO   = 3;
    localparam int          BASE_BLK_LO    = 0;
    // Option register layout.
    localparam int          OPT_MODE       = 15;
    localparam int          OPT_BYTE_LO    = 13;
    localparam int          OPT_RW_LO      = 11;
    localparam int          OPT_STROBE_SELECT_BIT       = 10;
    localparam int          OPT_ACK_LO     = 6;
    localparam int          OPT_SPACE_LO   = 4;
    localparam int          OPT_IPL_LO     = 1;
    localparam int          OPT_AUTOVECTOR_REQUEST       = 0;
    // Reset values.
    localparam logic [15:0] BOOT_BASE_RST  = 16'h0007;
    localparam logic [15:0] BOOT_OPT_RST   = 16'h7b70;
    localparam logic [15:0] GEN_BASE_RST   = 16'h0000;
    localparam logic [15:0] GEN_OPT_RST    = 16'h0000;
    // Encodings.
    localparam logic [3:0]  ACK_EXTERNAL   = 4'hf;
    localparam logic [1:0]  PA_DISCRETE    = 2'b00;
    localparam logic [1:0]  PA_ALTERNATE   = 2'b01;
    localparam logic [1:0]  PA_SEL8        = 2'b10;
    localparam logic [1:0]  PA_SEL16       = 2'b11;
    localparam logic [1:0]  SPACE_CPU      = 2'b00;
    localparam logic [1:0]  SPACE_USER     = 2'b01;
    localparam logic [1:0]  SPACE_SUP      = 2'b10;
    localparam logic [1:0]  SPACE_BOTH     = 2'b11;
    localparam logic [2:0]  FC_CPU         = 3'b111;
    localparam logic [3:0]  IACK_CODE      = 4'hf;
    localparam logic [1:0]  SIZE_BYTE      = 2'b01;
    localparam int          LATCH_SEL_LO   = 4;
    localparam int          LATCH_BITS     = 7;

    typedef enum logic {
        CYC_IDLE   = 1'b0,
        CYC_ACTIVE = 1'b1
    } csd_cycle_t;
endpackage

// File: verilog/csd_top.sv
// Chip-select decode unit: select matching, internal acknowledge and port latch.
//
// Notes on behaviour
// R01: Latch bit 7 ignores writes and always reads zero.
// R02: Latch bits 6..0 drive select pins 10..4 when assigned as discrete output.
// R03: Match space, base address, direction, and byte lane on sixteen-bit ports.
// R04: In interrupt acknowledge, priority on address 3..1 must equal priority mask; a mask of zero here accepts any level.
// R05: Asynchronous select asserts with address or data strobe per strobe bit.
// R06: Synchronous select times assertion to the E clock.
// R07: Acknowledge field picks external or internal acknowledge and wait states.
// R08: Cycle waits for acknowledge; slow peripherals rely on internal acknowledge.
// R09: CPU space compares base bits 15..3 with address 23..11.
// R10: Interrupt acknowledge is function code 111, code 1111 on address 19..16.
// R11: Interrupt acknowledge answered only for external requests, not internal.
// R12: Software programs base all ones, small block, read only, right lane first.
// R13: Unvectored interrupts end with autovector, external pin or internal select.
// R14: Reset sets low pin-assign bits, high bits from sampled data 6..1.
// R15: General selects reset disabled: base zero, 2K, CPU space, no waits.
// R16: Boot select resets enabled, both lanes, width from sampled data 0.
// R17: Boot select resets base zero, 1M, read/write, 13 waits, user or supervisor space.
// R18: Priority mask and autovector act only in CPU space.
// R19: Block size code chooses compared upper address bits, 2K up to 1M.
// R20: Pin assign 00 discrete, 01 alternate, 10 eight-bit, 11 sixteen-bit.
// R21: Select asserts only during the bus cycle and negates at its end.
`timescale 1ns/1ns
module csd_top (
    input  wire logic                  CORE_CLK_IN,
    input  wire logic                  RST_IN,
    input  wire logic [csd_pkg::AW-1:0] REG_ADDR_IN,
    input  wire logic [csd_pkg::DW-1:0] REG_WDATA_IN,
    input  wire logic                  REG_WR_IN,
    input  wire logic                  REG_RD_IN,
    output logic      [csd_pkg::DW-1:0] REG_RDATA_OUT,
    input  wire logic [7:0]            STRAP_DATA_IN,
    input  wire logic [23:0]           ADDR_IN,
    input  wire logic [2:0]            FUNCTION_CODE_IN,
    input  wire logic [1:0]            TRANSFER_SIZE_IN,
    input  wire logic                  READ_IN,
    input  wire logic                  ADDRESS_STROBE_N_IN,
    input  wire logic                  DATA_STROBE_N_IN,
    input  wire logic                  E_CLOCK_IN,
    input  wire logic                  IACK_INTERNAL_IN,
    output logic [csd_pkg::NUM_SEL-1:0] SELECT_PIN_OUT,
    output logic                       INT_ACK_OUT,
    output logic                       INT_ACK_WIDE_OUT,
    output logic                       AUTOVECTOR_REQUEST_OUT
);
    import csd_pkg::*;

    // Lowest address bit compared for each block size code.
    function automatic logic [4:0] blk_low(input logic [2:0] code);
        unique case (code)
            3'h0:    blk_low = 5'd11;
            3'h1:    blk_low = 5'd13;
            3'h2:    blk_low = 5'd14;
            3'h3:    blk_low = 5'd16;
            3'h4:    blk_low = 5'd17;
            3'h5:    blk_low = 5'd18;
            3'h6:    blk_low = 5'd19;
            default: blk_low = 5'd20;
        endcase
    endfunction

    // Byte lane match for a given pin assignment.
    function automatic logic lane_ok(input logic [1:0] pa, input logic [1:0] lanes,
                                     input logic a0, input logic [1:0] siz);
        if (pa == PA_SEL16) begin
            lane_ok = (lanes[1] & ~a0) | (lanes[0] & (a0 | (siz != SIZE_BYTE)));
        end else begin
            lane_ok = (lanes != 2'b00);
        end
    endfunction

    logic [15:0]        base_reg [NUM_SEL];
    logic [15:0]        opt_reg  [NUM_SEL];
    logic [1:0]         pa_reg   [NUM_SEL];
    logic [6:0]         latch;
    logic [7:0]         strap_s1, strap_s2, strap_s3;
    logic [7:0]         strap_val;
    csd_cycle_t         cycle;
    logic [3:0]         wait_cnt;
    logic [NUM_SEL-1:0] hit, assert_now, int_ack_req, autovector_request_req, wide_req;
    logic               iack_cycle, bus_on;
    logic [3:0]         reg_sel;
    logic               sel_hit;

    assign bus_on     = ~ADDRESS_STROBE_N_IN;
    assign iack_cycle = (FUNCTION_CODE_IN == FC_CPU) && (ADDR_IN[19:16] == IACK_CODE); // R10
    assign reg_sel    = REG_ADDR_IN[4:1];
    assign sel_hit    = REG_ADDR_IN[5] && (reg_sel < 4'(NUM_SEL));

    // Straps come from pins; a change counts only once the last two stages agree.
    always_ff @(posedge CORE_CLK_IN) begin
        strap_s1 <= STRAP_DATA_IN;
        strap_s2 <= strap_s1;
        strap_s3 <= strap_s2;
    end

    // One more clock of latency keeps a strap that is still settling out of the reset image.
    always_ff @(posedge CORE_CLK_IN) begin
        if (strap_s2 == strap_s3) begin
            strap_val <= strap_s3;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_SEL; g++) begin : gen_sel
            logic [12:0] mask;
            logic        space_ok, rw_ok, ipl_ok, addr_ok, cpu_sp;
            logic [1:0]  sp;
            logic [3:0]  ack_f;
            for (genvar b = 0; b < 13; b++) begin : gen_mask
                assign mask[b] = (5'(b + 11) >= blk_low(base_reg[g][2:0])); // R19
            end
            assign sp      = opt_reg[g][OPT_SPACE_LO +: 2];
            assign cpu_sp  = (sp == SPACE_CPU);
            assign ack_f   = opt_reg[g][OPT_ACK_LO +: 4];
            always_comb begin
                unique case (sp)
                    SPACE_CPU:  space_ok = (FUNCTION_CODE_IN == FC_CPU);
                    SPACE_USER: space_ok = ~FUNCTION_CODE_IN[2];
                    SPACE_SUP:  space_ok = FUNCTION_CODE_IN[2] && (FUNCTION_CODE_IN != FC_CPU);
                    SPACE_BOTH: space_ok = (FUNCTION_CODE_IN != FC_CPU);
                endcase
            end
            // CPU-space cycles use the same 23..11 compare as ordinary ones.
            assign addr_ok = ((base_reg[g][15:3] ^ ADDR_IN[23:11]) & mask) == 13'h0; // R09
            assign rw_ok   = READ_IN ? opt_reg[g][OPT_RW_LO] : opt_reg[g][OPT_RW_LO + 1];
            assign ipl_ok  = !(cpu_sp && iack_cycle) ||
                             (opt_reg[g][OPT_IPL_LO +: 3] == 3'h0) ||
                             (opt_reg[g][OPT_IPL_LO +: 3] == ADDR_IN[3:1]); // R04 R18
            // An internally requested acknowledge cycle is left to the internal module.
            assign hit[g]  = bus_on && space_ok && addr_ok && rw_ok && ipl_ok &&
                             !(iack_cycle && IACK_INTERNAL_IN) &&
                             lane_ok(pa_reg[g], opt_reg[g][OPT_BYTE_LO +: 2],
                                     ADDR_IN[0], TRANSFER_SIZE_IN); // R03 R11
            assign assert_now[g] = hit[g] && (opt_reg[g][OPT_MODE] ? E_CLOCK_IN : // R06
                                   (opt_reg[g][OPT_STROBE_SELECT_BIT] ? ~DATA_STROBE_N_IN : 1'b1)); // R05
            assign autovector_request_req[g] = hit[g] && cpu_sp && iack_cycle && opt_reg[g][OPT_AUTOVECTOR_REQUEST]; // R13
            assign int_ack_req[g] = hit[g] && !opt_reg[g][OPT_MODE] && !autovector_request_req[g] &&
                                    (ack_f != ACK_EXTERNAL) && (wait_cnt >= ack_f); // R07 R08
            assign wide_req[g] = int_ack_req[g] && (pa_reg[g] == PA_SEL16);
        end
    endgenerate

    // Bus cycle tracking: the wait counter starts at the strobe and saturates.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            cycle    <= CYC_IDLE;
            wait_cnt <= 4'h0;
        end else begin
            unique case (cycle)
                CYC_IDLE: begin
                    if (bus_on) begin
                        cycle <= CYC_ACTIVE;
                    end
                    wait_cnt <= 4'h0;
                end
                CYC_ACTIVE: begin
                    if (!bus_on) begin
                        cycle    <= CYC_IDLE;
                        wait_cnt <= 4'h0;
                    end else if (wait_cnt != 4'hf) begin
                        wait_cnt <= wait_cnt + 4'h1; // R08
                    end
                end
            endcase
        end
    end

    // Select and port latch pins; outputs lag the decode by one clock.
    always_ff @(posedge CORE_CLK_IN) begin
        for (int i = 0; i < NUM_SEL; i++) begin
            if (RST_IN) begin
                SELECT_PIN_OUT[i] <= 1'b1;
            end else if (pa_reg[i][1]) begin
                SELECT_PIN_OUT[i] <= ~(assert_now[i] && bus_on); // R20 R21
            end else if (pa_reg[i] == PA_DISCRETE && i >= LATCH_SEL_LO &&
                         i < LATCH_SEL_LO + LATCH_BITS) begin
                SELECT_PIN_OUT[i] <= latch[i - LATCH_SEL_LO]; // R02
            end else begin
                SELECT_PIN_OUT[i] <= 1'b1;
            end
        end
    end

    // Internal termination, held until the strobe negates.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            INT_ACK_OUT            <= 1'b0;
            INT_ACK_WIDE_OUT       <= 1'b0;
            AUTOVECTOR_REQUEST_OUT <= 1'b0;
        end else begin
            INT_ACK_OUT            <= |int_ack_req; // R07
            INT_ACK_WIDE_OUT       <= |wide_req;
            AUTOVECTOR_REQUEST_OUT <= |autovector_request_req; // R13
        end
    end

    // Configuration registers and straps.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            base_reg[0] <= BOOT_BASE_RST; // R17
            opt_reg[0]  <= BOOT_OPT_RST; // R16 R17
            pa_reg[0]   <= {1'b1, strap_val[0]}; // R16
            for (int i = 1; i < NUM_SEL; i++) begin
                base_reg[i] <= GEN_BASE_RST; // R15
                opt_reg[i]  <= GEN_OPT_RST; // R15
                pa_reg[i]   <= {strap_val[1 + ((i - 1) >> 1)], 1'b1}; // R14
            end
            latch <= 7'h00;
        end else if (REG_WR_IN) begin
            if (sel_hit && REG_ADDR_IN[0]) begin
                opt_reg[reg_sel] <= REG_WDATA_IN;
            end else if (sel_hit) begin
                base_reg[reg_sel] <= REG_WDATA_IN;
            end else if (REG_ADDR_IN == REG_LATCH) begin
                latch <= REG_WDATA_IN[6:0]; // R01
            end else if (REG_ADDR_IN == REG_PA_A) begin
                for (int i = 0; i < PA_A_FIELDS; i++) begin
                    pa_reg[i] <= REG_WDATA_IN[2*i +: 2];
                end
            end else if (REG_ADDR_IN == REG_PA_B) begin
                for (int i = PA_A_FIELDS; i < NUM_SEL; i++) begin
                    pa_reg[i] <= REG_WDATA_IN[2*(i - PA_A_FIELDS) +: 2];
                end
            end
        end
    end

    // Read port; unmapped offsets read zero.
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= 16'h0000;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT <= 16'h0000;
            if (sel_hit) begin
                REG_RDATA_OUT <= REG_ADDR_IN[0] ? opt_reg[reg_sel] : base_reg[reg_sel];
            end else if (REG_ADDR_IN == REG_LATCH) begin
                REG_RDATA_OUT <= {9'h000, latch}; // R01
            end else if (REG_ADDR_IN == REG_STATUS) begin
                REG_RDATA_OUT <= {4'h0, ~SELECT_PIN_OUT};
            end else if (REG_ADDR_IN == REG_PA_A) begin
                for (int i = 0; i < PA_A_FIELDS; i++) begin
                    REG_RDATA_OUT[2*i +: 2] <= pa_reg[i];
                end
            end else if (REG_ADDR_IN == REG_PA_B) begin
                for (int i = PA_A_FIELDS; i < NUM_SEL; i++) begin
                    REG_RDATA_OUT[2*(i - PA_A_FIELDS) +: 2] <= pa_reg[i];
                end
            end
        end else begin
            REG_RDATA_OUT <= 16'h0000;
        end
    end

    latch_msb_zero_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R01
        REG_RD_IN && REG_ADDR_IN == REG_LATCH |=> REG_RDATA_OUT[7] == 1'b0)
        else $error("latch bit 7 read as one");
    discrete_pin_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R02
        pa_reg[4] == PA_DISCRETE |=> SELECT_PIN_OUT[4] == $past(latch[0]))
        else $error("discrete pin does not follow latch");
    idle_negate_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R21
        !bus_on && pa_reg[0][1] |=> SELECT_PIN_OUT[0])
        else $error("boot select asserted outside a cycle");
    strobe_time_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R05
        pa_reg[1][1] && !opt_reg[1][OPT_MODE] && opt_reg[1][OPT_STROBE_SELECT_BIT] && DATA_STROBE_N_IN
        |=> SELECT_PIN_OUT[1])
        else $error("data-strobe select asserted early");
    sync_e_clock_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R06
        pa_reg[2][1] && opt_reg[2][OPT_MODE] && !E_CLOCK_IN |=> SELECT_PIN_OUT[2])
        else $error("synchronous select asserted without E clock");
    boot_wait_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R07
        hit == 12'h001 && opt_reg[0][OPT_ACK_LO +: 4] == 4'hd && wait_cnt < 4'hd
        |=> !INT_ACK_OUT)
        else $error("internal acknowledge before wait states elapsed");
    ack_in_cycle_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R08
        INT_ACK_OUT |-> $past(bus_on))
        else $error("internal acknowledge outside a cycle");
    internal_iack_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R11
        iack_cycle && IACK_INTERNAL_IN |=> !AUTOVECTOR_REQUEST_OUT && !INT_ACK_OUT)
        else $error("select answered an internal interrupt acknowledge");
    autovector_request_cpu_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R18
        $rose(AUTOVECTOR_REQUEST_OUT) |-> $past(iack_cycle))
        else $error("autovector outside interrupt acknowledge");
    reset_pa_a: assert property (@(posedge CORE_CLK_IN) // R14
        $past(RST_IN) && !RST_IN |-> pa_reg[5][0] && pa_reg[0][1])
        else $error("pin assignment reset value wrong");
    alt_pin_high_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R20
        pa_reg[1] == PA_ALTERNATE |=> SELECT_PIN_OUT[1])
        else $error("alternate-function pin driven low");
    rw_block_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R03
        pa_reg[1][1] && !READ_IN && !opt_reg[1][OPT_RW_LO + 1] |=> SELECT_PIN_OUT[1])
        else $error("select asserted for a refused direction");
    base_match_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R19
        pa_reg[1][1] && base_reg[1][2:0] == 3'h0 && ADDR_IN[23:11] != base_reg[1][15:3]
        |=> SELECT_PIN_OUT[1])
        else $error("2K select asserted outside its block");
    wide_ack_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R16
        int_ack_req[0] && pa_reg[0] == PA_SEL16 |=> INT_ACK_WIDE_OUT)
        else $error("sixteen-bit boot acknowledge not flagged wide");
    reset_regs_a: assert property (@(posedge CORE_CLK_IN) // R15 R17
        $past(RST_IN) && !RST_IN |-> base_reg[0] == BOOT_BASE_RST &&
            opt_reg[0] == BOOT_OPT_RST && opt_reg[1] == GEN_OPT_RST)
        else $error("select register reset value wrong");
endmodule

// File: bench/csd_periph_model.sv
// Far-side peripheral model: a slow memory that never drives its own acknowledge.
`timescale 1ns/1ns
module csd_periph_model (
    input  wire logic clk_in,
    input  wire logic sel_n_in,
    input  wire logic ack_in,
    output int        wait_cnt_out
);
    int cnt = 0;

    assign wait_cnt_out = cnt;

    // The device has no acknowledge driver, so it counts how long the cycle waits for the
    // internal one; the count restarts whenever the select is negated.
    always @(posedge clk_in) begin
        if (sel_n_in) begin
            cnt <= 0;
        end else if (!ack_in) begin
            cnt <= cnt + 1;
        end
    end
endmodule

// File: bench/csd_top_tb.sv
// Self-checking testbench for the chip-select decode unit.
`timescale 1ns/1ns
module csd_top_tb;
    import csd_pkg::*;
    typedef struct packed {
        logic [15:0] opt;
        logic [23:0] a;
        logic [2:0]  f;
        logic        r;
        logic [1:0]  s;
        logic        d;
        logic        e;
    } csd_case_t;
    // Option word, address, function code, read, size, data strobe level, expected pin.
    localparam csd_case_t CASES [9] = '{
        '{16'h68b0, 24'h123800, 3'h5, 1'b1, 2'h2, 1'b0, 1'b0},
        '{16'h68b0, 24'h1237fe, 3'h5, 1'b1, 2'h2, 1'b0, 1'b1},
        '{16'h68b0, 24'h123ffe, 3'h5, 1'b1, 2'h2, 1'b0, 1'b0},
        '{16'h68b0, 24'h123800, 3'h5, 1'b0, 2'h2, 1'b0, 1'b1},
        '{16'h68b0, 24'h123800, 3'h7, 1'b1, 2'h2, 1'b0, 1'b1},
        '{16'h48b0, 24'h123801, 3'h5, 1'b1, 2'h1, 1'b0, 1'b1},
        '{16'h48b0, 24'h123800, 3'h5, 1'b1, 2'h1, 1'b0, 1'b0},
        '{16'h6cb0, 24'h123800, 3'h5, 1'b1, 2'h2, 1'b1, 1'b1},
        '{16'h6cb0, 24'h123800, 3'h6, 1'b1, 2'h2, 1'b0, 1'b0}
    };
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic [AW-1:0]      reg_addr = '0;
    logic [DW-1:0]      reg_wdata = '0;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic               rd_d = 1'b0;
    logic [DW-1:0]      rdata;
    logic [7:0]         strap = 8'h00;
    logic [23:0]        addr = '0;
    logic [2:0]         fc = 3'h0;
    logic [1:0]         siz = 2'h2;
    logic               read = 1'b1;
    logic               as_n = 1'b1;
    logic               ds_n = 1'b1;
    logic               e_clock = 1'b0;
    logic               iack_int = 1'b0;
    logic [NUM_SEL-1:0] sel;
    logic               ack;
    logic               ack_w;
    logic               autovector_request;
    int                 wait_cnt;
    int                 error_cnt = 0;
    int                 checks = 0;
    logic [31:0]        seed = 32'hfcd4;
    logic [DW-1:0]      exp_q [$];

    csd_top u_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(reg_addr),
        .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
        .REG_RDATA_OUT(rdata), .STRAP_DATA_IN(strap), .ADDR_IN(addr),
        .FUNCTION_CODE_IN(fc), .TRANSFER_SIZE_IN(siz), .READ_IN(read),
        .ADDRESS_STROBE_N_IN(as_n), .DATA_STROBE_N_IN(ds_n), .E_CLOCK_IN(e_clock),
        .IACK_INTERNAL_IN(iack_int), .SELECT_PIN_OUT(sel), .INT_ACK_OUT(ack),
        .INT_ACK_WIDE_OUT(ack_w), .AUTOVECTOR_REQUEST_OUT(autovector_request));
    csd_periph_model u_model (.clk_in(clk), .sel_n_in(sel[0]), .ack_in(ack),
        .wait_cnt_out(wait_cnt));

    always #50 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // Pin-assign reset image: boot field low bit from strap 0, general fields high bit strapped.
    function automatic logic [15:0] pa_exp(input logic b);
        logic [15:0] v;
        int          i;
        v = 16'h0000;
        for (int j = 0; j < 7; j++) begin
            i = b ? j + 7 : j;
            if (i == 0) v[1:0] = {1'b1, strap[0]};
            else if (i < 12) v[2*j +: 2] = {strap[1 + ((i - 1) >> 1)], 1'b1};
        end
        return v;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_wr_t(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_rd_t(input logic [5:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic bus_start(input logic [23:0] a, input logic [2:0] f, input logic r,
                             input logic [1:0] s, input logic d);
        @(posedge clk);
        addr <= a; fc <= f; read <= r; siz <= s; as_n <= 1'b0; ds_n <= d;
    endtask

    task automatic bus_end;
        @(posedge clk);
        as_n <= 1'b1; ds_n <= 1'b1;
        cyc(2);
    endtask

    // Read data stand only in the cycle after the strobe, so the note is taken exactly then.
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d) check(rdata, exp_q.pop_front());
    end

    initial begin
        #(100 * 20000);
        error_cnt++;
        wrap_up();
    end

    initial begin
        seed = xs(seed);
        strap <= seed[7:0];
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        reg_rd_t(REG_PA_A, pa_exp(1'b0));
        reg_rd_t(REG_PA_B, pa_exp(1'b1));
        reg_rd_t(6'h20, 16'h0007);
        reg_rd_t(6'h21, 16'h7b70);
        reg_rd_t(6'h22, 16'h0000);
        reg_rd_t(6'h23, 16'h0000);
        // Boot fetch at address zero in supervisor program space, thirteen waits inside.
        bus_start(24'h000000, 3'h6, 1'b1, 2'h2, 1'b0);
        cyc(2);
        check(16'(sel), 16'hffe);
        for (int n = 0; n < 30 && ack !== 1'b1; n++) cyc(1);
        check(16'(wait_cnt >= 13 && wait_cnt <= 16), 16'h0001);
        check(16'(ack_w), 16'(strap[0]));
        bus_end();
        check(16'({sel[0], ack}), 16'h0002);
        reg_wr_t(REG_PA_A, 16'h00ff);
        reg_wr_t(REG_PA_B, 16'h0000);
        reg_rd_t(REG_PA_A, 16'h00ff);
        reg_wr_t(REG_LATCH, 16'hffff);
        reg_rd_t(REG_LATCH, 16'h007f);
        seed = xs(seed);
        reg_wr_t(REG_LATCH, seed[15:0]);
        reg_rd_t(REG_LATCH, {9'h000, seed[6:0]});
        reg_rd_t(6'h3f, 16'h0000);
        cyc(2);
        check(16'(sel), 16'({1'b1, seed[6:0], 4'hf}));
        reg_rd_t(REG_STATUS, 16'({1'b0, ~seed[6:0], 4'h0}));
        reg_wr_t(6'h22, 16'h1238);
        foreach (CASES[k]) begin
            reg_wr_t(6'h23, CASES[k].opt);
            bus_start(CASES[k].a, CASES[k].f, CASES[k].r, CASES[k].s, CASES[k].d);
            cyc(2);
            check(16'(sel[1]), 16'(CASES[k].e));
            bus_end();
        end
        // Synchronous select waits for the E clock before asserting.
        reg_wr_t(6'h26, 16'h2000);
        reg_wr_t(6'h27, 16'hf830);
        bus_start(24'h200000, 3'h5, 1'b1, 2'h2, 1'b0);
        cyc(3);
        check(16'(sel[3]), 16'h0001);
        @(posedge clk);
        e_clock <= 1'b1;
        cyc(2);
        check(16'(sel[3]), 16'h0000);
        bus_end();
        @(posedge clk);
        e_clock <= 1'b0;
        // Interrupt acknowledge: matching level, other level, internal requester.
        reg_wr_t(6'h24, 16'hfffb);
        reg_wr_t(6'h25, 16'h2bcb);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            iack_int <= (i == 2);
            bus_start({20'hfffff, (i == 1) ? 3'h3 : 3'h5, 1'b1}, 3'h7, 1'b1, 2'h1, 1'b0);
            cyc(3);
            check(16'(autovector_request), 16'(i == 0));
            check(16'(sel[2]), 16'(i != 0));
            bus_end();
        end
        cyc(3);
        check(16'(exp_q.size()), 16'h0000);
        wrap_up();
    end
endmodule
